// ==== test/ssbc_partner.sv ====
module ssbc_partner (
  input wire logic sckLine,
  input wire logic fromPort,
  output logic toPort,
  output logic sckDrive,
  output logic selDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shiftOut;
  logic [7:0] heardByte;
  logic leading;

  initial begin
    toPort = 1'b0;
    sckDrive = 1'b0;
    selDrive = 1'b1;
    leading = 1'b0;
    shiftOut = 8'h00;
    heardByte = 8'h00;
  end

  // The reply is in place before the far master may start a transfer
  task automatic load_reply(input logic [7:0] b);
    shiftOut = b;
    toPort = b[7];
  endtask

  // Spent bits are replaced by inverted ones so a stale line never looks valid
  always @(negedge sckLine) begin
    if (!leading) begin
      shiftOut = {shiftOut[6:0], ~shiftOut[7]};
      toPort = shiftOut[7];
    end
  end

  always @(posedge sckLine) begin
    heardByte = {heardByte[6:0], fromPort};
  end

  // Clock stands low outside the frame; select frames the whole byte
  task automatic lead_frame(input logic [7:0] b);
    leading = 1'b1;
    selDrive = 1'b0;
    #40;
    for (int i = 0; i < 8; i++) begin
      toPort = b[7 - i];
      #40 sckDrive = 1'b1;
      #40 sckDrive = 1'b0;
    end
    #40 selDrive = 1'b1;
    toPort = ~toPort;
    leading = 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module tb_top import ssbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, psel, penable, pwrite, chipIdle, err, prevSck;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sckOut, sckOe, sdo, sdoOe, selOut, selOe, irq;
  logic partSck, partSdi, partSel;
  int failures, compares, toggles;
  wire sckLine = sckOe ? sckOut : partSck;
  wire selLine = selOe ? selOut : partSel;

  ssbc_port dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chipIdle(chipIdle), .serialClockIn(sckLine), .serialClockOut(sckOut), .serialClockOe(sckOe),
    .serialIn(partSdi), .serialOut(sdo), .serialOutOe(sdoOe), .selectIn(selLine),
    .selectOut(selOut), .selectOe(selOe), .irq(irq));

  ssbc_partner partner_u (.sckLine(sckLine), .fromPort(sdo), .toPort(partSdi), .sckDrive(partSck),
    .selDrive(partSel));

  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask

  // Polls status so a hung transfer ends the run instead of the bench
  task automatic wait_stat(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_OFFSET, 32'h0000_0000);
      n++;
    end while ((rd & m) === 32'h0000_0000 && n < 300);
    if (n >= 300) begin
      failures++;
      close_out();
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    chipIdle = 1'b0;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) chk_reg("reset value", 8'(a * 4), 32'h0000_0000);
    `CHK("clock enable", 1'b0, sckOe)
    wr(STAT_OFFSET, 32'hFFFF_FFFF);
    chk_reg("status", STAT_OFFSET, 32'h0000_A000);
    wr(CON1_OFFSET, 32'h0000_0200);
    chk_reg("control one", CON1_OFFSET, 32'h0000_0000);
    wr(CON1_OFFSET, 32'h0000_0220);
    chk_reg("control one", CON1_OFFSET, 32'h0000_0220);
    wr(CON1_OFFSET, 32'h0000_0020);
    chk_reg("control one", CON1_OFFSET, 32'h0000_0020);
    `CHK("clock enable", 1'b1, sckOe)
    `CHK("data enable", 1'b1, sdoOe)
    chipIdle <= 1'b1;
    wr(IRQ_MASK_OFFSET, 32'h0000_0001);
    partner_u.load_reply(8'hA5);
    wr(BUF_OFFSET, 32'h0000_003C);
    repeat (40) @(posedge clock);
    chk_reg("status", STAT_OFFSET, 32'h0000_A002);
    `CHK("irq", 1'b0, irq)
    chipIdle <= 1'b0;
    wait_stat(32'h0000_0001);
    `CHK("status", 32'h0000_A001, rd)
    `CHK("irq", 1'b1, irq)
    chk_reg("irq status", IRQ_STAT_OFFSET, 32'h0000_0003);
    wr(IRQ_MASK_OFFSET, 32'h0000_0000);
    settle();
    `CHK("irq", 1'b0, irq)
    wr(IRQ_MASK_OFFSET, 32'h0000_0001);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(IRQ_STAT_OFFSET, 32'h0000_0007);
    settle();
    `CHK("irq", 1'b0, irq)
    chk_reg("data", BUF_OFFSET, 32'h0000_00A5);
    `CHK("partner heard", 8'h3C, partner_u.heardByte)
    chk_reg("status", STAT_OFFSET, 32'h0000_A000);
    partner_u.load_reply(8'h5A);
    wr(BUF_OFFSET, 32'h0000_0011);
    wait_stat(32'h0000_0001);
    partner_u.load_reply(8'hC3);
    wr(BUF_OFFSET, 32'h0000_0022);
    wait_stat(32'h0000_0040);
    `CHK("status", 32'h0000_A041, rd)
    chk_reg("data", BUF_OFFSET, 32'h0000_005A);
    wr(STAT_OFFSET, 32'h0000_A040);
    chk_reg("status", STAT_OFFSET, 32'h0000_A040);
    wr(STAT_OFFSET, 32'h0000_8000);
    chk_reg("status", STAT_OFFSET, 32'h0000_8000);
    wr(CON1_OFFSET, 32'h0000_0220);
    partner_u.load_reply(8'h69);
    wr(BUF_OFFSET, 32'h0000_0081);
    wait_stat(32'h0000_0001);
    chk_reg("late sample data", BUF_OFFSET, 32'h0000_0069);
    `CHK("partner heard", 8'h81, partner_u.heardByte)
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    `CHK("slave error", 1'b1, err)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("slave error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    // Framed master keeps its clock running with nothing to send
    wr(CON2_OFFSET, 32'h0000_8000);
    settle();
    `CHK("sync enable", 1'b1, selOe)
    toggles = 0;
    @(negedge clock);
    prevSck = sckOut;
    repeat (64) begin
      @(negedge clock);
      if (sckOut !== prevSck) toggles++;
      prevSck = sckOut;
    end
    `CHK("clock runs", 1'b1, toggles > 4)
    wr(BUF_OFFSET, 32'h0000_0055);
    toggles = 0;
    repeat (40) begin
      @(negedge clock);
      if (selOut === 1'b0) toggles++;
    end
    `CHK("sync pulse cycles", 2 * HALF_CYCLES_INT, toggles)
    wait_stat(32'h0000_0001);
    `CHK("status", 32'h0000_8001, rd)
    apb(1'b0, BUF_OFFSET, 32'h0000_0000);
    wr(CON2_OFFSET, 32'h0000_0000);
    wr(CON1_OFFSET, 32'h0000_0080);
    wr(BUF_OFFSET, 32'h0000_0096);
    settle();
    `CHK("clock enable", 1'b0, sckOe)
    partner_u.lead_frame(8'hC3);
    wait_stat(32'h0000_0001);
    `CHK("status", 32'h0000_8001, rd)
    chk_reg("data", BUF_OFFSET, 32'h0000_00C3);
    wr(STAT_OFFSET, 32'h0000_0000);
    settle();
    `CHK("data enable", 1'b0, sdoOe)
    close_out();
  end
endmodule

// ==== verilog/ssbc_link_if.sv ====
interface ssbc_link_if;
  import ssbc_pkg::*;
  logic on;
  logic halt;
  logic masterMode;
  logic wordMode;
  logic clockIdleHigh;
  logic sampleLate;
  logic framed;
  logic selEnable;
  logic syncActiveHigh;
  logic sckIn;
  logic sdiIn;
  logic selIn;
  logic txValid;
  ssbc_word_t txData;
  logic txTake;
  logic rxDone;
  ssbc_word_t rxData;
  logic sckOut;
  logic sdoOut;
  logic selOut;

  modport ctrl(
    output on, halt, masterMode, wordMode, clockIdleHigh, sampleLate, framed, selEnable,
    output syncActiveHigh, sckIn, sdiIn, selIn, txValid, txData,
    input txTake, rxDone, rxData, sckOut, sdoOut, selOut
  );
  modport engine(
    input on, halt, masterMode, wordMode, clockIdleHigh, sampleLate, framed, selEnable,
    input syncActiveHigh, sckIn, sdiIn, selIn, txValid, txData,
    output txTake, rxDone, rxData, sckOut, sdoOut, selOut
  );
endinterface

// ==== verilog/ssbc_pkg.sv ====
package ssbc_pkg;
  // Register byte addresses on the APB window
  localparam logic [7:0] STAT_OFFSET = 8'h00;
  localparam logic [7:0] BUF_OFFSET = 8'h04;
  localparam logic [7:0] CON1_OFFSET = 8'h08;
  localparam logic [7:0] CON2_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;

  // port_status_control fields
  localparam int PORT_ENABLE_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int RX_OVERRUN_BIT = 6;
  localparam int TX_FULL_BIT = 1;
  localparam int RX_FULL_BIT = 0;

  // port_control_one fields
  localparam int WORD_MODE_BIT = 10;
  localparam int SAMPLE_PHASE_BIT = 9;
  localparam int SLAVE_SELECT_BIT = 7;
  localparam int CLOCK_POL_BIT = 6;
  localparam int MASTER_BIT = 5;
  localparam logic [15:0] CON1_MASK = 16'h06E0;

  // port_control_two fields
  localparam int FRAMED_BIT = 15;
  localparam int SYNC_POL_BIT = 13;
  localparam logic [15:0] CON2_MASK = 16'hA000;

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;

  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

  // Serial timing: half period of the generated serial clock
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int SERIAL_HALF_NS = 16;
  localparam int HALF_CYCLES_INT = (SERIAL_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYCLES_INT - 1);

  localparam int SYNC_PINS = 4;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;

  typedef logic [15:0] ssbc_word_t;
endpackage

// ==== verilog/ssbc_port.sv ====
// Function
// - Enable bit 15 turns the port on and hands the four pins to it.
// - Idle-stop bit 13 freezes the port while the chip is idle.
// - A word arriving while the last is unread is dropped; overflow bit 6 sets.
// - Transmit-full bit 1 sets on buffer write, clears on move to shifter.
// - Receive-full bit 0 sets on shifter-to-holding move, clears on buffer read.
// - Transmit holding moves into the shifter as a transfer starts, freeing it.
// - Framed mode runs the clock continuously in master mode only; a sync pulse opens each frame.
// - Sample phase acts only in master mode, settable only with master enable.
// - Unused status bits 14, 12 to 7 and 5 to 2 read zero.
//
// Design decisions made here: the APB register port and the register offsets.
module ssbc_port import ssbc_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  input wire logic chipIdle,
  input wire logic serialClockIn,
  output wire logic serialClockOut,
  output wire logic serialClockOe,
  input wire logic serialIn,
  output wire logic serialOut,
  output wire logic serialOutOe,
  input wire logic selectIn,
  output wire logic selectOut,
  output wire logic selectOe,
  output wire logic irq
);
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  ssbc_link_if link();

  // Two-flop synchronisers for everything arriving from the pins
  logic [SYNC_PINS-1:0] pinRaw;
  logic [SYNC_PINS-1:0] syncStage1;
  logic [SYNC_PINS-1:0] syncStage2;
  assign pinRaw = {chipIdle, selectIn, serialIn, serialClockIn};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : gSync
      always_ff @(posedge clock) begin
        if (reset) begin
          syncStage1[gi] <= 1'b0;
          syncStage2[gi] <= 1'b0;
        end else begin
          syncStage1[gi] <= pinRaw[gi];
          syncStage2[gi] <= syncStage1[gi];
        end
      end
    end
  endgenerate
  wire sckSync = syncStage2[0];
  wire sdiSync = syncStage2[1];
  wire selSync = syncStage2[2];
  wire idleSync = syncStage2[3];

  // Registers
  logic portEnable;
  logic idleStop;
  logic overflow;
  logic txFull;
  logic rxFull;
  ssbc_word_t txHolding;
  ssbc_word_t rxHolding;
  ssbc_word_t ctlOne;
  ssbc_word_t ctlTwo;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;

  // APB decode
  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitStat = isReg(paddr, STAT_OFFSET);
  wire hitBuf = isReg(paddr, BUF_OFFSET);
  wire hitCon1 = isReg(paddr, CON1_OFFSET);
  wire hitCon2 = isReg(paddr, CON2_OFFSET);
  wire hitIrqStat = isReg(paddr, IRQ_STAT_OFFSET);
  wire hitIrqMask = isReg(paddr, IRQ_MASK_OFFSET);
  wire mapped = hitStat | hitBuf | hitCon1 | hitCon2 | hitIrqStat | hitIrqMask;
  wire wrAccess = accessPh & pwrite;
  wire wrStat = wrAccess & hitStat;
  wire wrBuf = wrAccess & hitBuf;
  wire wrCon1 = wrAccess & hitCon1;
  wire wrCon2 = wrAccess & hitCon2;
  wire wrIrqStat = wrAccess & hitIrqStat;
  wire wrIrqMask = wrAccess & hitIrqMask;
  wire rdBuf = accessPh & ~pwrite & hitBuf;

  assign pready = 1'b1;
  assign pslverr = accessPh & ~mapped;

  // Control fields
  wire masterEnable = ctlOne[MASTER_BIT];
  wire slaveSelEn = ctlOne[SLAVE_SELECT_BIT];
  wire framedEn = ctlTwo[FRAMED_BIT];
  ssbc_word_t statusView;
  always_comb begin
    statusView = REG_RESET;
    statusView[PORT_ENABLE_BIT] = portEnable;
    statusView[IDLE_STOP_BIT] = idleStop;
    statusView[RX_OVERRUN_BIT] = overflow;
    statusView[TX_FULL_BIT] = txFull;
    statusView[RX_FULL_BIT] = rxFull;
  end

  // A word landing in a read's setup cycle with receive full clear is the one that read returns and clears
  wire [15:0] readMux =
    hitStat ? statusView :
    hitBuf ? ((link.rxDone & ~rxFull) ? link.rxData : rxHolding) :
    hitCon1 ? ctlOne :
    hitCon2 ? ctlTwo :
    hitIrqStat ? {13'h0000, irqStat} :
    hitIrqMask ? {13'h0000, irqMask} : REG_RESET;

  // Sample phase is only kept when master enable is set in the same write
  wire [15:0] con1Write = pwdata[15:0] & CON1_MASK;
  wire smpAllowed = pwdata[MASTER_BIT] & pwdata[SAMPLE_PHASE_BIT];
  ssbc_word_t next_ctlOne;
  always_comb begin
    next_ctlOne = con1Write;
    next_ctlOne[SAMPLE_PHASE_BIT] = smpAllowed;
  end

  // Receive handoff: a read in the same cycle makes room for the new word
  wire rxAccept = link.rxDone & (~rxFull | rdBuf);
  wire ovfEvent = link.rxDone & rxFull & ~rdBuf;
  wire ovfClear = wrStat & ~pwdata[RX_OVERRUN_BIT];
  wire next_rxFull = rxAccept | (rxFull & ~rdBuf);
  wire next_txFull = wrBuf | (txFull & ~link.txTake);
  wire next_overflow = ovfEvent | (overflow & ~ovfClear);
  wire [IRQ_W-1:0] irqEvents = {ovfEvent, link.txTake, rxAccept};
  wire [IRQ_W-1:0] irqClear = wrIrqStat ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] next_irqStat = irqEvents | (irqStat & ~irqClear);

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= PRDATA_RESET;
    end else if (setupPh & ~pwrite) begin
      prdata <= {16'h0000, readMux};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      portEnable <= 1'b0;
      idleStop <= 1'b0;
    end else if (wrStat) begin
      portEnable <= pwdata[PORT_ENABLE_BIT];
      idleStop <= pwdata[IDLE_STOP_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctlOne <= REG_RESET;
      ctlTwo <= REG_RESET;
    end else begin
      if (wrCon1) begin
        ctlOne <= next_ctlOne;
      end
      if (wrCon2) begin
        ctlTwo <= pwdata[15:0] & CON2_MASK;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txFull <= 1'b0;
      rxFull <= 1'b0;
      overflow <= 1'b0;
    end else begin
      txFull <= next_txFull;
      rxFull <= next_rxFull;
      overflow <= next_overflow;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txHolding <= REG_RESET;
    end else if (wrBuf) begin
      txHolding <= pwdata[15:0];
    end
  end

  // Overrun leaves the unread word in place and drops the newcomer
  always_ff @(posedge clock) begin
    if (reset) begin
      rxHolding <= REG_RESET;
    end else if (rxAccept) begin
      rxHolding <= link.rxData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irqStat <= {IRQ_W{1'b0}};
      irqMask <= {IRQ_W{1'b0}};
    end else begin
      irqStat <= next_irqStat;
      if (wrIrqMask) begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqStat & irqMask);

  // Engine hookup
  assign link.on = portEnable;
  assign link.halt = idleStop & idleSync;
  assign link.masterMode = masterEnable;
  assign link.wordMode = ctlOne[WORD_MODE_BIT];
  assign link.clockIdleHigh = ctlOne[CLOCK_POL_BIT];
  assign link.sampleLate = ctlOne[SAMPLE_PHASE_BIT] & masterEnable;
  assign link.framed = framedEn;
  // Framed mode takes priority in the engine should software set both; serialOutOe still follows slave select
  assign link.selEnable = slaveSelEn & ~framedEn;
  assign link.syncActiveHigh = ctlTwo[SYNC_POL_BIT];
  assign link.sckIn = sckSync;
  assign link.sdiIn = sdiSync;
  assign link.selIn = selSync;
  assign link.txValid = txFull;
  assign link.txData = txHolding;

  ssbc_shifter u_shifter (
    .clock(clock),
    .reset(reset),
    .l(link.engine)
  );

  // Pin takeover only while the port is enabled
  assign serialClockOut = link.sckOut;
  assign serialClockOe = portEnable & masterEnable;
  assign serialOut = link.sdoOut;
  assign serialOutOe = portEnable & (masterEnable | ~slaveSelEn | ~selSync);
  assign selectOut = link.selOut;
  assign selectOe = portEnable & masterEnable & framedEn;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence statRead;
    setupPh & ~pwrite & hitStat;
  endsequence

  sequence statWrite;
    wrStat;
  endsequence

  sequence bufReadSetup;
    setupPh & ~pwrite & hitBuf;
  endsequence

  txfull_set_a: assert property (wrBuf |=> txFull)
    else $error("buffer write did not set transmit full");
  txfull_clear_a: assert property (link.txTake & ~wrBuf |=> ~txFull)
    else $error("transmit full not cleared on move to shifter");
  rxfull_clear_a: assert property (rdBuf & ~link.rxDone |=> ~rxFull)
    else $error("buffer read did not clear receive full");
  rxfull_set_a: assert property (rxAccept |=> rxFull && rxHolding == $past(link.rxData))
    else $error("received word not moved to holding");
  overrun_drop_a: assert property (ovfEvent |=> overflow && $stable(rxHolding))
    else $error("overrun did not drop word and flag it");
  overrun_hold_a: assert property (overflow & ~ovfClear |=> overflow)
    else $error("overflow flag lost without a zero write");
  reserved_zero_a: assert property (statRead |=> (prdata[15:0] & ~16'hA043) == 16'h0000)
    else $error("unused status bits read nonzero");
  pins_released_a: assert property (~portEnable |-> ~serialClockOe & ~serialOutOe & ~selectOe)
    else $error("pins driven while port disabled");
  idle_freeze_a: assert property (link.halt & portEnable |-> ~link.rxDone ##1 $stable(serialClockOut))
    else $error("port kept running in idle stop");
  smp_master_a: assert property (ctlOne[SAMPLE_PHASE_BIT] |-> masterEnable)
    else $error("sample phase held without master enable");
  read_fresh_a: assert property (bufReadSetup ##0 rxAccept |=> prdata[15:0] == rxHolding)
    else $error("buffer read missed the word landing in its setup cycle");
  enable_write_a: assert property (statWrite |=> portEnable == $past(pwdata[PORT_ENABLE_BIT]))
    else $error("port enable did not follow the status write");
  idle_write_a: assert property (statWrite |=> idleStop == $past(pwdata[IDLE_STOP_BIT]))
    else $error("idle stop did not follow the status write");
  idle_no_take_a: assert property (link.halt |-> ~link.txTake)
    else $error("transmit word taken while frozen in idle");
  // Flags keep their value between their set and clear events
  txfull_hold_a: assert property (txFull & ~link.txTake |=> txFull)
    else $error("transmit full lost without a move to the shifter");
  rxfull_hold_a: assert property (rxFull & ~rdBuf |=> rxFull)
    else $error("receive full lost without a buffer read");
  overrun_clear_a: assert property (ovfClear & ~ovfEvent |=> ~overflow)
    else $error("overflow not cleared by a zero write");
  select_release_a: assert property (~masterEnable & slaveSelEn & selSync |-> ~serialOutOe)
    else $error("data pin driven while slave deselected");
endmodule

// ==== verilog/ssbc_shifter.sv ====
module ssbc_shifter import ssbc_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  ssbc_link_if.engine l
);
  logic [4:0] bitsLeft;
  ssbc_word_t shiftReg;
  logic sckActive;
  logic sckPrev;
  logic sampled;
  logic [3:0] divCnt;
  logic syncOut;
  logic rxDoneR;

  // Nothing starts, ends or hands over while frozen in idle, nor while off except a word finished on the edge the engine goes off
  wire run = l.on & ~l.halt;
  wire [4:0] frameBits = l.wordMode ? WORD_BITS : BYTE_BITS;
  wire busy = bitsLeft != 5'h00;
  wire tick = run & l.masterMode & (divCnt == HALF_LAST);
  wire mToggle = tick & (busy | l.framed);
  // In framed mode a frame may only open on a trailing edge so the clock never pauses
  wire mStart = tick & ~busy & l.txValid & (~l.framed | sckActive);
  wire sEdge = run & ~l.masterMode & (l.sckIn != sckPrev);
  wire sActiveLvl = l.sckIn ^ l.clockIdleHigh;
  wire lead = l.masterMode ? (mToggle & ~sckActive) : (sEdge & sActiveLvl);
  wire trail = l.masterMode ? (mToggle & sckActive) : (sEdge & ~sActiveLvl);
  wire selActive = ~l.selEnable | ~l.selIn;
  wire syncSeen = l.selIn == l.syncActiveHigh;
  wire sStart = ~l.masterMode & lead & ~busy & (l.framed ? syncSeen : selActive);
  wire abortS = ~l.masterMode & ~l.framed & ~selActive;
  wire late = l.sampleLate & l.masterMode;
  wire inBit = late ? l.sdiIn : sampled;

  assign l.txTake = mStart | (sStart & l.txValid);
  assign l.rxDone = rxDoneR & ~l.halt;
  assign l.rxData = l.wordMode ? shiftReg : {8'h00, shiftReg[7:0]};
  assign l.sckOut = sckActive ^ l.clockIdleHigh;
  assign l.sdoOut = l.wordMode ? shiftReg[15] : shiftReg[7];
  assign l.selOut = l.syncActiveHigh ? syncOut : ~syncOut;

  always_ff @(posedge clock) begin
    if (reset | ~l.on) begin
      bitsLeft <= 5'h00;
      shiftReg <= REG_RESET;
      sckActive <= 1'b0;
      sckPrev <= 1'b0;
      sampled <= 1'b0;
      divCnt <= 4'h0;
      syncOut <= 1'b0;
      rxDoneR <= 1'b0;
    end else if (~l.halt) begin
      sckPrev <= l.sckIn;
      divCnt <= tick ? 4'h0 : divCnt + 4'h1;
      rxDoneR <= 1'b0;
      if (mToggle) begin
        sckActive <= ~sckActive;
      end
      if (lead & ~late) begin
        sampled <= l.sdiIn;
      end
      if (mStart | sStart) begin
        shiftReg <= l.txValid ? l.txData : REG_RESET;
        bitsLeft <= frameBits;
        syncOut <= l.framed;
      end else if (abortS) begin
        bitsLeft <= 5'h00;
      end else if (trail & busy) begin
        shiftReg <= {shiftReg[14:0], inBit};
        bitsLeft <= bitsLeft - 5'h01;
        syncOut <= 1'b0;
        rxDoneR <= bitsLeft == 5'h01;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence framedRun;
    l.on & ~l.halt & l.framed & l.masterMode;
  endsequence
  sequence clockStuck;
    (l.on & ~l.halt & l.framed & l.masterMode & $stable(sckActive))[*8];
  endsequence

  take_starts_shift_a: assert property (l.txTake |=> busy)
    else $error("transmit take did not start a shift");
  framed_clock_a: assert property (not clockStuck)
    else $error("framed serial clock stopped");
  sync_pulse_a: assert property (framedRun and l.txTake |=> syncOut ##1 syncOut)
    else $error("frame sync pulse missing at frame start");
endmodule
